// *** bench/apb_host.sv ***
// APB host model that issues single register transfers for the bench
`timescale 1ns/100ps
`default_nettype none
module apb_host (
	input wire logic pclk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	// ------------------------------------------------------------
	// idle bus at time zero
	// ------------------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// ------------------------------------------------------------
	// one transfer: setup, then access held until pready is sampled
	// ------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output bit ok);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		ok = (pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines no longer show the last request
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : apb_host
`default_nettype wire

// *** bench/pixel_correction_adjust_test.sv ***
// self-checking bench for the pixel correction adjust block
`timescale 1ns/100ps
`default_nettype none
module pixel_correction_adjust_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	corr_pkg::pix_t pix_in, pix_out;
	logic [65:0] bus_q[$];
	logic [15:0] pix_q[$];
	logic [15:0] arg, d;
	integer seed;
	int n_fail = 0;
	int n_compared = 0;
	localparam logic [31:0] G2 = (32'h4666 * 32'h4666) >> 14;

	pixel_correction_adjust dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .pix_in(pix_in),
		.pix_out(pix_out));
	apb_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	// ------------------------------------------------------------
	// clock, report and compare
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic cmp_bus(input logic [32:0] got, input logic [65:0] e);
		if (e[65:33] != 33'h0) begin
			n_compared++;
			if ((got & e[65:33]) !== (e[32:0] & e[65:33])) begin
				n_fail++;
				$display("wrong value at %0t: got %h expected %h", $time, got, e[32:0]);
			end
		end
	endtask : cmp_bus

	task automatic cmp_pix(input logic [15:0] got, input logic [15:0] e);
		n_compared++;
		if (got !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, e);
		end
	endtask : cmp_pix

	// watcher: each result takes the oldest note off its queue
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			cmp_bus({pslverr, prdata}, bus_q.pop_front());
		end
		if (pix_out.valid === 1'b1) begin
			cmp_pix(pix_out.data, pix_q.pop_front());
		end
	end

	// ------------------------------------------------------------
	// driver tasks
	// ------------------------------------------------------------
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat,
		input logic [32:0] m, input logic [32:0] e);
		bit ok;
		bus_q.push_back({m, e});
		host.xfer(wr, a, dat, rd, ok);
		if (!ok) begin
			n_fail++;
			summarize();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		bus(1'b1, a, dat, {33{1'b1}}, 33'h0);
	endtask : wr

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			bus(1'b0, corr_pkg::A_STAT, 32'h0, 33'h0, 33'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 200);
		if (rd[0] !== 1'b0) begin
			n_fail++;
			summarize();
		end
	endtask : wait_idle

	// launch, wait, then check done or err and clear them
	task automatic cmd(input logic [2:0] op, input logic [11:0] f, input logic [11:0] l,
		input logic eg, input logic err);
		wr(corr_pkg::A_CMD, {4'h0, l, f, eg, op});
		wait_idle();
		bus(1'b0, corr_pkg::A_STAT, 32'h0, err ? 33'h3 : 33'h7, {30'h0, !err, err, 1'b0});
		wr(corr_pkg::A_STAT, 32'h6);
	endtask : cmd

	task automatic peek(input logic [7:0] col, input logic [15:0] g, input logic [15:0] o);
		wr(corr_pkg::A_PEEK, {24'h0, col});
		bus(1'b0, corr_pkg::A_PEEK_DATA, 32'h0, {33{1'b1}}, {1'b0, g, o});
	endtask : peek

	task automatic pix(input logic [7:0] idx, input logic [15:0] e);
		@(posedge pclk);
		pix_q.push_back(e);
		pix_in <= {1'b1, idx, d};
		@(posedge pclk);
		pix_in.valid <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : pix

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		seed = 95;
		arg = 16'($random(seed));
		arg = {{8{arg[7]}}, arg[7:0]};
		pix_in = '0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		wait_idle();
		peek(8'd0, 16'h4000, 16'h0);
		bus(1'b0, 8'h1C, 32'h0, {33{1'b1}}, {1'b1, 32'h0}); // unmapped place
		$display("test reset finished");
		wr(corr_pkg::A_CTRL, 32'h0);
		wr(corr_pkg::A_ARG, {16'h0, arg});
		cmd(3'h1, 12'd99, 12'd108, 1'b1, 1'b1);
		peek(8'd99, 16'h4000, 16'h0);
		wr(corr_pkg::A_CTRL, 32'h1);
		cmd(3'h1, 12'd99, 12'd108, 1'b1, 1'b0);
		peek(8'd98, 16'h4000, 16'h0);
		peek(8'd99, 16'h4000, arg);
		peek(8'd108, 16'h4000, arg);
		peek(8'd109, 16'h4000, 16'h0);
		wr(corr_pkg::A_ARG, 32'h3);
		cmd(3'h1, 12'd5, 12'd200, 1'b0, 1'b0);
		peek(8'd5, 16'h4000, 16'h3);
		peek(8'd6, 16'h4000, 16'h0);
		cmd(3'h1, 12'd10, 12'd9, 1'b1, 1'b1);
		cmd(3'h1, 12'd250, 12'd256, 1'b1, 1'b1);
		cmd(3'h7, 12'd10, 12'd10, 1'b1, 1'b1);
		peek(8'd10, 16'h4000, 16'h0);
		peek(8'd250, 16'h4000, 16'h0);
		$display("test offset adjust finished");
		wr(corr_pkg::A_CTRL, 32'h3);
		wr(corr_pkg::A_ARG, 32'h4666);
		cmd(3'h2, 12'd99, 12'd108, 1'b1, 1'b0);
		peek(8'd99, 16'h4666, arg);
		peek(8'd109, 16'h4000, 16'h0);
		cmd(3'h3, 12'd0, 12'd0, 1'b0, 1'b0);
		wr(corr_pkg::A_ARG, 32'h2);
		cmd(3'h1, 12'd99, 12'd0, 1'b0, 1'b0);
		peek(8'd99, 16'h4666, arg + 16'h2);
		cmd(3'h4, 12'd0, 12'd0, 1'b0, 1'b0);
		peek(8'd99, 16'h4666, arg);
		wr(corr_pkg::A_CTRL, 32'h0B);
		cmd(3'h4, 12'd0, 12'd0, 1'b0, 1'b0);
		peek(8'd99, 16'h4666, 16'h0);
		wr(corr_pkg::A_CTRL, 32'h3);
		cmd(3'h4, 12'd0, 12'd0, 1'b0, 1'b0);
		$display("test offset flash finished");
		wr(corr_pkg::A_LOC, 32'h2);
		cmd(3'h5, 12'd0, 12'd0, 1'b0, 1'b0);
		wr(corr_pkg::A_ARG, 32'h4666);
		cmd(3'h2, 12'd99, 12'd0, 1'b0, 1'b0);
		peek(8'd99, G2[15:0], arg);
		wr(corr_pkg::A_LOC, 32'h3);
		cmd(3'h6, 12'd0, 12'd0, 1'b0, 1'b0);
		peek(8'd99, 16'h4000, arg);
		wr(corr_pkg::A_LOC, 32'h2);
		cmd(3'h6, 12'd0, 12'd0, 1'b0, 1'b0);
		peek(8'd99, 16'h4666, arg);
		wr(corr_pkg::A_LOC, 32'h5);
		bus(1'b0, corr_pkg::A_STAT, 32'h0, 33'h2, 33'h2);
		bus(1'b0, corr_pkg::A_LOC, 32'h0, {33{1'b1}}, 33'h2);
		wr(corr_pkg::A_STAT, 32'h6);
		$display("test gain flash finished");
		// floor above any byte offset, so the subtraction never clamps at zero
		d = 16'({$random(seed)} % 4096) | 16'h0100;
		wr(corr_pkg::A_CTRL, 32'h6);
		pix(8'd99, 16'((32'(d) * 32'h4666) >> 14));
		pix(8'd109, d);
		wr(corr_pkg::A_CTRL, 32'h1);
		pix(8'd5, d - 16'h3);
		pix(8'd99, d - arg);
		wr(corr_pkg::A_CTRL, 32'h0);
		pix(8'd99, d);
		$display("test pixel path finished");
		summarize();
	end
endmodule : pixel_correction_adjust_test
`default_nettype wire

// *** core/corr_pkg.sv ***
// package: constants, register layouts and arithmetic for pixel correction adjust
//
// Behaviour
// R01: adjust commands only refine an already enabled correction; base tables are kept
// R02: offset adjust adds a signed DN value to stored offsets over the column range
// R03: gain adjust multiplies stored gains over the column range by a fractional factor
// R04: with no end column given, only the start column pixel is adjusted
// R05: columns are zero based; the hundredth pixel is column 99
// R06: offset save overwrites the flash offset table of the current analog gain
// R07: offset load drops unsaved offset edits and restores the table from flash
// R08: gain save overwrites the flash location chosen earlier, one of five
// R09: gain load drops unsaved gain edits and reloads the chosen flash location
// R10: gain display mode applies adjusted gains to acquired line pixels
// R11: reversed or out-of-sensor column ranges are rejected, tables unchanged
package corr_pkg;

	// ------------------------------------------------------------
	// geometry and formats
	// ------------------------------------------------------------
	localparam int unsigned WIDTH = 256;
	localparam int unsigned IDX_W = 8;
	localparam int unsigned COL_W = 12;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned N_AGAIN = 4;
	localparam int unsigned AG_W = 2;
	localparam int unsigned N_LOC = 5;
	localparam int unsigned LOC_W = 3;
	localparam int unsigned GAIN_FRAC = 14;
	localparam logic [COL_W-1:0] LAST_COL = 12'h0FF;
	localparam logic [DATA_W-1:0] GAIN_ONE = 16'h4000;
	localparam logic [DATA_W-1:0] OFF_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] SAT_MAX = 16'hFFFF;
	localparam logic [DATA_W-1:0] SAT_POS = 16'h7FFF;
	localparam logic [DATA_W-1:0] SAT_NEG = 16'h8000;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_ARG = 8'h08;
	localparam logic [7:0] A_LOC = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_PEEK = 8'h14;
	localparam logic [7:0] A_PEEK_DATA = 8'h18;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_ADJ_OFF = 3'h1,
		OP_ADJ_GAIN = 3'h2,
		OP_SAVE_OFF = 3'h3,
		OP_LOAD_OFF = 3'h4,
		OP_SAVE_GAIN = 3'h5,
		OP_LOAD_GAIN = 3'h6
	} op_t;

	typedef struct packed {
		logic [26:0] rsv;
		logic [AG_W-1:0] again;
		logic disp;
		logic gain_en;
		logic off_en;
	} ctrl_t;

	typedef struct packed {
		logic [3:0] rsv;
		logic [COL_W-1:0] last;
		logic [COL_W-1:0] first;
		logic end_given;
		op_t op;
	} cmd_t;

	typedef struct packed {
		logic [28:0] rsv;
		logic done;
		logic err;
		logic busy;
	} stat_t;

	typedef struct packed {
		logic [DATA_W-1:0] gain;
		logic [DATA_W-1:0] off;
	} peek_t;

	typedef struct packed {
		logic valid;
		logic [IDX_W-1:0] idx;
		logic [DATA_W-1:0] data;
	} pix_t;

	// ------------------------------------------------------------
	// arithmetic
	// ------------------------------------------------------------
	// signed offset sum, saturated to the 16-bit signed range
	function automatic logic [DATA_W-1:0] add_off(input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b);
		logic [DATA_W:0] s;
		s = {a[DATA_W-1], a} + {b[DATA_W-1], b};
		if (s[DATA_W] != s[DATA_W-1]) begin
			add_off = s[DATA_W] ? SAT_NEG : SAT_POS;
		end else begin
			add_off = s[DATA_W-1:0];
		end
	endfunction : add_off

	// unsigned value times a 2.14 fractional gain, saturated
	function automatic logic [DATA_W-1:0] mul_gain(input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] g);
		logic [2*DATA_W-1:0] p;
		p = a * g;
		if ((p >> (GAIN_FRAC + DATA_W)) != 32'h0) begin
			mul_gain = SAT_MAX;
		end else begin
			mul_gain = p[GAIN_FRAC +: DATA_W];
		end
	endfunction : mul_gain

	function automatic logic is_adj(input op_t op);
		is_adj = (op == OP_ADJ_OFF) || (op == OP_ADJ_GAIN);
	endfunction : is_adj

endpackage : corr_pkg

// *** core/pixel_apply.sv ***
// module: applies working offset and gain to one pixel per clock
`timescale 1ns/100ps
`default_nettype none
module pixel_apply (
	input wire logic pclk,
	input wire logic presetn,
	input wire corr_pkg::pix_t pix_in,
	input wire logic [corr_pkg::DATA_W-1:0] off,
	input wire logic [corr_pkg::DATA_W-1:0] gain,
	input wire logic off_on,
	input wire logic gain_on,
	output corr_pkg::pix_t pix_out
);
	localparam int unsigned W = corr_pkg::DATA_W;

	corr_pkg::pix_t q, d;

	// offset subtract with clamp, then gain when display is on
	always_comb begin
		logic [W+1:0] t;
		logic [W-1:0] v;
		v = pix_in.data;
		t = {2'b00, pix_in.data} - {{2{off[W-1]}}, off};
		if (!off_on) begin
			v = pix_in.data;
		end else if (t[W+1]) begin
			v = corr_pkg::OFF_ZERO;
		end else if (t[W]) begin
			v = corr_pkg::SAT_MAX;
		end else begin
			v = t[W-1:0];
		end
		d = pix_in;
		d.data = gain_on ? corr_pkg::mul_gain(v, gain) : v; // see R10
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pix_out = q;

endmodule : pixel_apply
`default_nettype wire

// *** core/pixel_correction_adjust.sv ***
// module: APB command engine that adjusts, saves and reloads pixel correction tables
`timescale 1ns/100ps
`default_nettype none
module pixel_correction_adjust (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire corr_pkg::pix_t pix_in,
	output corr_pkg::pix_t pix_out
);
	localparam int unsigned W = corr_pkg::DATA_W;
	localparam int unsigned IW = corr_pkg::IDX_W;
	localparam int unsigned CW = corr_pkg::COL_W;

	typedef enum logic [1:0] {S_INIT, S_IDLE, S_ADJ, S_COPY} st_t;

	typedef struct packed {
		st_t st;
		corr_pkg::ctrl_t ctrl;
		corr_pkg::op_t op;
		logic [corr_pkg::LOC_W-1:0] loc;
		logic [corr_pkg::LOC_W-1:0] bank;
		logic [W-1:0] arg;
		logic [CW-1:0] col;
		logic [CW-1:0] last;
		logic err;
		logic done;
		logic [IW-1:0] peek;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_t;

	state_t q, d;

	// ------------------------------------------------------------
	// tables: working copies and flash images
	// ------------------------------------------------------------
	logic [W-1:0] work_off [corr_pkg::WIDTH];
	logic [W-1:0] work_gain [corr_pkg::WIDTH];
	logic [W-1:0] flash_off [corr_pkg::N_AGAIN][corr_pkg::WIDTH];
	logic [W-1:0] flash_gain [corr_pkg::N_LOC][corr_pkg::WIDTH];

	logic acc, wr, mapped, kick, bad, init;
	logic off_we, gain_we, foff_we, fgain_we;
	logic [W-1:0] off_wd, gain_wd, foff_wd, fgain_wd;
	logic [IW-1:0] widx;
	logic [CW-1:0] cmd_last;
	logic [31:0] rd_mux;
	corr_pkg::cmd_t cmd;
	corr_pkg::stat_t stat_w, stat_r;
	corr_pkg::peek_t peek_r;

	assign widx = q.col[IW-1:0];
	assign init = (q.st == S_INIT);
	assign cmd = corr_pkg::cmd_t'(pwdata);
	// omitted end column means a single pixel
	assign cmd_last = cmd.end_given ? cmd.last : cmd.first; // see R04

	// ------------------------------------------------------------
	// table write strobes and data
	// ------------------------------------------------------------
	// offsets change on adjust and load; base stays until changed
	assign off_we = init | (q.st == S_ADJ & q.op == corr_pkg::OP_ADJ_OFF)
		| (q.st == S_COPY & q.op == corr_pkg::OP_LOAD_OFF); // see R01
	assign gain_we = init | (q.st == S_ADJ & q.op == corr_pkg::OP_ADJ_GAIN)
		| (q.st == S_COPY & q.op == corr_pkg::OP_LOAD_GAIN);
	assign foff_we = (q.st == S_COPY) & (q.op == corr_pkg::OP_SAVE_OFF);
	assign fgain_we = (q.st == S_COPY) & (q.op == corr_pkg::OP_SAVE_GAIN);

	// add the signed DN value to the stored offset, or reload from flash
	assign off_wd = init ? corr_pkg::OFF_ZERO : (q.st == S_ADJ)
		? corr_pkg::add_off(work_off[widx], q.arg) // see R02
		: flash_off[q.bank[corr_pkg::AG_W-1:0]][widx]; // see R07
	// scale the stored gain by the factor, or reload from chosen location
	assign gain_wd = init ? corr_pkg::GAIN_ONE : (q.st == S_ADJ)
		? corr_pkg::mul_gain(work_gain[widx], q.arg) // see R03
		: flash_gain[q.bank][widx]; // see R09
	assign foff_wd = init ? corr_pkg::OFF_ZERO : work_off[widx];
	assign fgain_wd = init ? corr_pkg::GAIN_ONE : work_gain[widx];

	// table memories, one column per clock
	always_ff @(posedge pclk) begin
		if (off_we) begin
			work_off[widx] <= off_wd;
		end
		if (gain_we) begin
			work_gain[widx] <= gain_wd;
		end
		for (int b = 0; b < corr_pkg::N_AGAIN; b++) begin
			if (init | (foff_we & (q.bank == 3'(b)))) begin
				flash_off[b][widx] <= foff_wd; // see R06
			end
		end
		for (int b = 0; b < corr_pkg::N_LOC; b++) begin
			if (init | (fgain_we & (q.bank == 3'(b)))) begin
				flash_gain[b][widx] <= fgain_wd; // see R08
			end
		end
	end

	// ------------------------------------------------------------
	// register read view
	// ------------------------------------------------------------
	always_comb begin
		stat_r = '0;
		stat_r.busy = (q.st != S_IDLE);
		stat_r.err = q.err;
		stat_r.done = q.done;
		peek_r.off = work_off[q.peek];
		peek_r.gain = work_gain[q.peek];
		mapped = 1'b1;
		rd_mux = '0;
		case (paddr)
			corr_pkg::A_CTRL: rd_mux = q.ctrl;
			corr_pkg::A_CMD: rd_mux = {4'h0, q.last, q.col, 1'b1, q.op};
			corr_pkg::A_ARG: rd_mux = 32'(q.arg);
			corr_pkg::A_LOC: rd_mux = 32'(q.loc);
			corr_pkg::A_STAT: rd_mux = stat_r;
			corr_pkg::A_PEEK: rd_mux = 32'(q.peek);
			corr_pkg::A_PEEK_DATA: rd_mux = peek_r;
			default: mapped = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// next state: bus, command intake, sequencer
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		stat_w = corr_pkg::stat_t'(pwdata);
		acc = psel & penable;
		wr = acc & q.pready & pwrite & ~q.pslverr;
		kick = 1'b0;
		bad = 1'b0;
		// one wait state, then answer with registered data
		if (acc & ~q.pready) begin
			d.pready = 1'b1;
			d.pslverr = ~mapped;
			d.prdata = (mapped & ~pwrite) ? rd_mux : '0;
		end else begin
			d.pready = 1'b0;
			d.pslverr = 1'b0;
			d.prdata = '0;
		end
		// writes take effect at the edge that completes the transfer
		if (wr) begin
			case (paddr)
				corr_pkg::A_CTRL: begin
					d.ctrl = corr_pkg::ctrl_t'(pwdata);
					d.ctrl.rsv = '0;
				end
				corr_pkg::A_CMD: kick = 1'b1;
				corr_pkg::A_ARG: d.arg = pwdata[W-1:0];
				corr_pkg::A_LOC: begin
					if (pwdata < corr_pkg::N_LOC) begin
						d.loc = pwdata[corr_pkg::LOC_W-1:0]; // see R08
					end else begin
						d.err = 1'b1;
					end
				end
				corr_pkg::A_STAT: begin
					if (stat_w.err) begin
						d.err = 1'b0;
					end
					if (stat_w.done) begin
						d.done = 1'b0;
					end
				end
				corr_pkg::A_PEEK: d.peek = pwdata[IW-1:0];
				default: d.err = q.err;
			endcase
		end
		// command intake: busy, illegal opcode, disabled or bad range refuse
		if (kick) begin
			bad = (q.st != S_IDLE)
				| (cmd.op == corr_pkg::OP_NONE) | (cmd.op > corr_pkg::OP_LOAD_GAIN)
				| ((cmd.op == corr_pkg::OP_ADJ_OFF) & ~q.ctrl.off_en) // see R01
				| ((cmd.op == corr_pkg::OP_ADJ_GAIN) & ~q.ctrl.gain_en) // see R01
				| (corr_pkg::is_adj(cmd.op) & ((cmd.first > cmd_last)
				| (cmd_last > corr_pkg::LAST_COL))); // see R11
			if (bad) begin
				d.err = 1'b1;
			end else begin
				d.op = cmd.op;
				if (corr_pkg::is_adj(cmd.op)) begin
					d.st = S_ADJ;
					d.col = cmd.first; // see R05
					d.last = cmd_last; // see R04
				end else begin
					d.st = S_COPY;
					d.col = '0;
					d.last = corr_pkg::LAST_COL;
				end
				// offsets bank on analog gain, gains on the chosen location
				if (cmd.op == corr_pkg::OP_SAVE_OFF || cmd.op == corr_pkg::OP_LOAD_OFF) begin
					d.bank = {1'b0, q.ctrl.again}; // see R06
				end else begin
					d.bank = q.loc; // see R09
				end
			end
		end
		// sequencer walks one column per clock; done set wins over clear
		unique case (q.st)
			S_INIT: begin
				if (q.col == corr_pkg::LAST_COL) begin
					d.st = S_IDLE;
					d.col = '0;
				end else begin
					d.col = CW'(q.col + 12'h001);
				end
			end
			S_IDLE: begin
			end
			S_ADJ, S_COPY: begin
				if (q.col == q.last) begin
					d.st = S_IDLE;
					d.done = 1'b1;
				end else begin
					d.col = CW'(q.col + 12'h001);
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pready = q.pready;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;

	// ------------------------------------------------------------
	// pixel path
	// ------------------------------------------------------------
	pixel_apply u_apply (
		.pclk(pclk),
		.presetn(presetn),
		.pix_in(pix_in),
		.off(work_off[pix_in.idx]),
		.gain(work_gain[pix_in.idx]),
		.off_on(q.ctrl.off_en),
		.gain_on(q.ctrl.disp), // see R10
		.pix_out(pix_out)
	);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_off_add;
		logic [IW-1:0] c;
		logic [W-1:0] v;
		(q.st == S_ADJ && q.op == corr_pkg::OP_ADJ_OFF,
			c = widx, v = corr_pkg::add_off(work_off[widx], q.arg)) |=> work_off[c] == v;
	endproperty

	property p_gain_mul;
		logic [IW-1:0] c;
		logic [W-1:0] v;
		(q.st == S_ADJ && q.op == corr_pkg::OP_ADJ_GAIN,
			c = widx, v = corr_pkg::mul_gain(work_gain[widx], q.arg)) |=> work_gain[c] == v;
	endproperty

	property p_save_off;
		logic [IW-1:0] c;
		logic [W-1:0] v;
		logic [corr_pkg::AG_W-1:0] b;
		(foff_we, c = widx, v = work_off[widx], b = q.bank[corr_pkg::AG_W-1:0])
			|=> flash_off[b][c] == v;
	endproperty

	property p_load_off;
		logic [IW-1:0] c;
		logic [W-1:0] v;
		(q.st == S_COPY && q.op == corr_pkg::OP_LOAD_OFF,
			c = widx, v = flash_off[q.bank[corr_pkg::AG_W-1:0]][widx]) |=> work_off[c] == v;
	endproperty

	property p_save_gain;
		logic [IW-1:0] c;
		logic [W-1:0] v;
		logic [corr_pkg::LOC_W-1:0] b;
		(fgain_we, c = widx, v = work_gain[widx], b = q.bank) |=> flash_gain[b][c] == v;
	endproperty

	property p_load_gain;
		logic [IW-1:0] c;
		logic [W-1:0] v;
		(q.st == S_COPY && q.op == corr_pkg::OP_LOAD_GAIN,
			c = widx, v = flash_gain[q.bank][widx]) |=> work_gain[c] == v;
	endproperty

	property p_display;
		logic [W-1:0] v;
		(pix_in.valid && q.ctrl.disp && !q.ctrl.off_en,
			v = corr_pkg::mul_gain(pix_in.data, work_gain[pix_in.idx]))
			|=> pix_out.valid && pix_out.data == v;
	endproperty

	a_adj_needs_enable: assert property ($rose(q.st == S_ADJ) && q.op == corr_pkg::OP_ADJ_OFF
		|-> $past(q.ctrl.off_en)) else $error("offset adjust ran while disabled"); // see R01
	a_offset_add: assert property (p_off_add) else $error("offset sum wrong"); // see R02
	a_gain_mul: assert property (p_gain_mul) else $error("gain product wrong"); // see R03
	a_single_pixel: assert property (kick && !bad && corr_pkg::is_adj(cmd.op) && !cmd.end_given
		|=> q.st == S_ADJ ##1 q.st == S_IDLE && q.done) else $error("not one pixel"); // see R04
	a_start_column: assert property (kick && !bad && corr_pkg::is_adj(cmd.op)
		|=> q.col == $past(cmd.first)) else $error("start column shifted"); // see R05
	a_save_offset: assert property (p_save_off) else $error("offset save wrong"); // see R06
	a_load_offset: assert property (p_load_off) else $error("offset load wrong"); // see R07
	a_save_gain: assert property (p_save_gain) else $error("gain save wrong"); // see R08
	a_load_gain: assert property (p_load_gain) else $error("gain load wrong"); // see R09
	a_display_gain: assert property (p_display) else $error("display gain wrong"); // see R10
	a_range_reject: assert property (kick && corr_pkg::is_adj(cmd.op) && cmd.first > cmd_last
		|=> q.err && q.st != S_ADJ) else $error("bad range accepted"); // see R11

	c_adj_range: cover property (q.st == S_ADJ && q.col != q.last);
	c_save_gain: cover property (fgain_we && q.bank == 3'h2);
	c_reject: cover property (kick && bad);
	c_load_off: cover property (q.st == S_COPY && q.op == corr_pkg::OP_LOAD_OFF);

endmodule : pixel_correction_adjust
`default_nettype wire
